// *** sim/asipr_remote.sv ***
`timescale 1ns/1ps
`default_nettype none
// ========================================
// remote serial device: sends bench-built frames, captures 14 bit slots
module asipr_remote #(
   parameter int BIT = 16
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // serial line
   input wire logic line_in,
   output logic line_out,
   // bench side
   input wire logic go,
   input wire logic [13:0] frame,
   output logic busy,
   output logic [13:0] cap,
   output logic [7:0] ncap
);
   logic [13:0] sh;
   logic [4:0] ts;
   logic [4:0] rs;
   int tc;
   int rc;
   logic prev;
   logic rbusy;
   assign line_out = busy ? sh[0] : 1'b1; // idle at mark level
   always_ff @(posedge clk) begin
      if (rst || (!busy && !go)) begin
         busy <= 1'b0;
         tc <= 0;
         ts <= 5'h00;
      end else if (!busy) begin
         busy <= 1'b1;
         sh <= frame;
      end else if (tc == BIT - 1) begin
         tc <= 0;
         sh <= {1'b1, sh[13:1]}; // start first, lsb first
         ts <= ts + 5'h01;
         busy <= (ts != 5'h0D);
      end else begin
         tc <= tc + 1;
      end
   end
   // capture starts on a falling edge, samples near mid-bit
   always_ff @(posedge clk) begin
      prev <= line_in;
      if (rst) begin
         rbusy <= 1'b0;
         ncap <= 8'h00;
      end else if (!rbusy) begin
         rbusy <= prev && !line_in;
         rc <= BIT / 2;
         rs <= 5'h00;
      end else if (rc == 0) begin
         cap[rs] <= line_in;
         rc <= BIT - 1;
         rs <= rs + 5'h01;
         rbusy <= (rs != 5'h0D);
         if (rs == 5'h0D) ncap <= ncap + 8'h01;
      end else begin
         rc <= rc - 1;
      end
   end
endmodule
`default_nettype wire

// *** sim/asipr_uart_asserts.sv ***
`timescale 1ns/1ps
`default_nettype none
// ========================================
// bus handshake, pin ownership and interrupt pulse checks
module asipr_checker (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // register bus
   input wire logic [4:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest,
   // pins and events
   input wire logic serial_out_oe,
   input wire logic request_to_send_oe,
   input wire logic tx_irq,
   input wire logic rx_irq
);
   logic [15:0] mode_sh;
   logic [15:0] stat_sh;
   wire [15:0] lane = {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
   wire [15:0] wdat = avs_writedata[15:0] & lane;
   // shadow the whole written low half of mode and status, from which pin ownership is decided
   always_ff @(posedge clk) begin
      if (rst) begin
         mode_sh <= 16'h0000;
         stat_sh <= 16'h0000;
      end else if (avs_write && !avs_waitrequest) begin
         if (avs_address[4:2] == 3'h0) mode_sh <= (mode_sh & ~lane) | wdat;
         if (avs_address[4:2] == 3'h1) stat_sh <= (stat_sh & ~lane) | wdat;
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   sequence s_req;
      (avs_read || avs_write) && avs_waitrequest;
   endsequence
   sequence s_ans;
      !avs_waitrequest ##1 avs_waitrequest;
   endsequence
   AST_ONE_WAIT: assert property (s_req |=> s_ans)
      else $error("bus answer not one cycle after request");
   AST_IDLE_WAIT: assert property (!(avs_read || avs_write) |-> avs_waitrequest)
      else $error("waitrequest low without request");
   AST_RD_UPPER: assert property (avs_read && !avs_waitrequest |-> avs_readdata[31:16] == 16'h0000)
      else $error("upper read data not zero");
   AST_OFF_RELEASE: assert property (!mode_sh[15] [*3] |-> !serial_out_oe && !request_to_send_oe)
      else $error("pins driven while module off");
   AST_TX_RELEASE: assert property (!stat_sh[10] [*3] |-> !serial_out_oe)
      else $error("transmit pin driven while transmit off");
   AST_TX_OWN: assert property ((mode_sh[15] && stat_sh[10]) [*3] |-> serial_out_oe)
      else $error("transmit pin not driven while enabled");
   AST_RTS_UNUSED: assert property ((mode_sh[9:8] == 2'b00) [*3] |-> !request_to_send_oe)
      else $error("rts pin driven with pin usage 00");
   AST_RTS_USED: assert property ((mode_sh[15] && mode_sh[9:8] != 2'b00) [*3] |-> request_to_send_oe)
      else $error("rts pin not driven with pin usage set");
   AST_TXIRQ_PULSE: assert property (tx_irq |=> !tx_irq)
      else $error("tx interrupt longer than one cycle");
   AST_RXIRQ_PULSE: assert property (rx_irq |=> !rx_irq)
      else $error("rx interrupt longer than one cycle");
endmodule
bind asipr_uart asipr_checker asipr_checker_inst (.clk, .rst, .avs_address, .avs_read,
   .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
   .serial_out_oe, .request_to_send_oe, .tx_irq, .rx_irq);
`default_nettype wire

// *** sim/asipr_uart_bench.sv ***
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin num_errors++; \
   $display("[FAIL] %s exp %h got %h", n, e, g); end end
module asipr_uart_bench;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic rd = 1'b0;
   logic wr = 1'b0;
   logic go = 1'b0;
   logic idl = 1'b0;
   logic [4:0] ad = 5'h00;
   logic [31:0] wd = 32'h0000_0000;
   logic [13:0] fr = 14'h3FFF;
   logic [15:0] q;
   logic [7:0] n0;
   wire [31:0] rdat;
   wire wrq, sout, soe, txi, rxi, sin, busy;
   wire [13:0] cap;
   wire [7:0] ncap;
   int num_errors = 0;
   int cmp_count = 0;
   int ntx = 0;
   int nrx = 0;
   int t0, pd, s, i;
   initial forever #25 clk = ~clk;
   always @(posedge clk) begin
      ntx += txi;
      nrx += rxi;
   end
   asipr_uart asipr_uart_inst (.clk(clk), .rst(rst), .avs_address(ad), .avs_read(rd),
      .avs_write(wr), .avs_writedata(wd), .avs_byteenable(4'hF), .avs_readdata(rdat),
      .avs_waitrequest(wrq), .serial_in_pin(sin), .serial_out_pin(sout),
      .serial_out_oe(soe), .clear_to_send_pin_n(1'b0), .request_to_send_pin_n(),
      .request_to_send_oe(), .chip_idle(idl), .chip_sleep(1'b0), .tx_irq(txi),
      .rx_irq(rxi), .wake_irq());
   // undriven transmit line rests high through the board pull-up
   asipr_remote asipr_remote_inst (.clk(clk), .rst(rst), .line_in(soe ? sout : 1'b1),
      .line_out(sin), .go(go), .frame(fr), .busy(busy), .cap(cap), .ncap(ncap));
   // ========================================
   // bench tasks
   task summarize;
      $display("errors %0d compares %0d", num_errors, cmp_count);
      if (num_errors == 0 && cmp_count > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task tmo(input int n, input int lim);
      if (n >= lim) begin
         $display("[FAIL] wait limit exp %0d got %0d", lim, n);
         num_errors++;
         summarize;
      end
   endtask
   task acc(input bit w, input logic [4:0] a, input logic [15:0] d);
      int n;
      n = 0;
      @(posedge clk);
      rd <= !w;
      wr <= w;
      ad <= a;
      wd <= {16'h0000, d};
      do begin
         @(posedge clk);
         n++;
      end while (wrq !== 1'b0 && n < 20);
      q = rdat[15:0];
      rd <= 1'b0;
      wr <= 1'b0;
      tmo(n, 20);
   endtask
   task rdchk(input logic [4:0] a, input logic [15:0] e, input string nm);
      acc(0, a, 16'h0000);
      `CHK(nm, e, q)
   endtask
   task waitcap;
      int n;
      n = 0;
      while (ncap === n0 && n < 3000) begin
         @(posedge clk);
         n++;
      end
      tmo(n, 3000);
   endtask
   task idle_tx;
      int n;
      n = 0;
      do begin
         acc(0, 5'h04, 16'h0000);
         n++;
      end while (q[8] !== 1'b1 && n < 500);
      tmo(n, 500);
   endtask
   task send(input logic [13:0] f);
      int n;
      n = 0;
      @(posedge clk);
      fr <= f;
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      @(posedge clk);
      while (busy !== 1'b0 && n < 400) begin
         @(posedge clk);
         n++;
      end
      tmo(n, 400);
   endtask
   function automatic logic [13:0] fexp(input logic [8:0] d, input int pd, input int s2);
      int p;
      fexp = 14'h0000;
      p = (pd == 3) ? 9 : 8;
      for (int k = 0; k < p; k++) fexp[1 + k] = d[k];
      if (pd == 1 || pd == 2) begin
         fexp[p + 1] = ^d[7:0] ^ (pd == 2);
         p++;
      end
      fexp[p + 1] = 1'b1;
      fexp[p + 2] = s2[0];
   endfunction
   // ========================================
   // main sequence
   initial begin
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      rdchk(5'h00, 16'h0000, "mode rst");
      rdchk(5'h04, 16'h0110, "stat rst");
      rdchk(5'h14, 16'h0000, "unmapped");
      acc(1, 5'h00, 16'h4400);
      rdchk(5'h00, 16'h0000, "mode rsv");
      acc(1, 5'h00, 16'h8100);
      acc(1, 5'h04, 16'h5400);
      repeat (3) @(posedge clk);
      `CHK("txinv idle", 1'b0, sout)
      acc(1, 5'h04, 16'h1400);
      // the idle-low edge started a stray capture in the remote; let it run out
      repeat (250) @(posedge clk);
      for (pd = 0; pd < 4; pd++) for (s = 0; s < 2; s++) begin
         acc(1, 5'h00, 16'h8000 | {13'h0000, pd[1:0], s[0]});
         n0 = ncap;
         t0 = ntx;
         acc(1, 5'h0C, 16'h01B5);
         acc(1, 5'h0C, 16'h0000);
         waitcap;
         `CHK("frame", fexp(9'h1B5, pd, s), cap)
         idle_tx;
         `CHK("tx irq", 2, ntx - t0)
      end
      acc(1, 5'h00, 16'h8000);
      acc(1, 5'h04, 16'h1C00);
      n0 = ncap;
      acc(1, 5'h0C, 16'h0000);
      acc(1, 5'h0C, 16'h0055);
      waitcap;
      `CHK("break", 14'h2000, cap)
      idle_tx;
      `CHK("break clr", 1'b0, q[11])
      repeat (6) acc(1, 5'h0C, 16'h00FF);
      rdchk(5'h04, 16'h1610, "tx full");
      acc(1, 5'h04, 16'h1000);
      rdchk(5'h04, 16'h1110, "tx abort");
      acc(1, 5'h04, 16'h14C0);
      t0 = nrx;
      for (i = 0; i < 5; i++) send({5'h1F, 8'h30 + i[7:0], 1'b0});
      repeat (40) @(posedge clk);
      rdchk(5'h04, 16'h15D3, "overrun");
      `CHK("rx irq", 1, nrx - t0)
      rdchk(5'h10, 16'h0030, "rx head");
      acc(1, 5'h04, 16'h14C0);
      rdchk(5'h04, 16'h15D0, "flushed");
      acc(1, 5'h00, 16'h8002);
      acc(1, 5'h04, 16'h1400);
      send({3'h7, 1'b1, 1'b0, 8'h01, 1'b0});
      send({3'h7, 1'b0, 1'b1, 8'h01, 1'b0});
      repeat (40) @(posedge clk);
      rdchk(5'h04, 16'h1519, "parity_error_flag");
      rdchk(5'h10, 16'h0001, "rx a");
      rdchk(5'h04, 16'h1515, "framing_error_flag");
      rdchk(5'h10, 16'h0001, "rx b");
      rdchk(5'h04, 16'h1510, "rx empty");
      acc(1, 5'h00, 16'hA000);
      idl <= 1'b1;
      acc(1, 5'h0C, 16'h0011);
      repeat (40) @(posedge clk);
      rdchk(5'h04, 16'h1410, "halted");
      idl <= 1'b0;
      idle_tx;
      acc(1, 5'h00, 16'h8040);
      acc(1, 5'h0C, 16'h003C);
      idle_tx;
      repeat (40) @(posedge clk);
      rdchk(5'h10, 16'h003C, "loopback");
      summarize;
   end
endmodule
`default_nettype wire

// *** verilog/asipr_defines.vh ***
`ifndef ASIPR_DEFINES_VH
`define ASIPR_DEFINES_VH
// ====================================================
// register word offsets (address bits 4:2)
`define ASIPR_OFS_MODE 3'h0
`define ASIPR_OFS_STAT 3'h1
`define ASIPR_OFS_DIV 3'h2
`define ASIPR_OFS_TXD 3'h3
`define ASIPR_OFS_RXD 3'h4
// ====================================================
// mode register fields
`define ASIPR_M_ON 15
`define ASIPR_M_HALT 13
`define ASIPR_M_INFRARED_CODEC_ON 12
`define ASIPR_M_RTS_PIN_MODE 11
`define ASIPR_M_PIN_HI 9
`define ASIPR_M_PIN_LO 8
`define ASIPR_M_WAKE 7
`define ASIPR_M_LOOP 6
`define ASIPR_M_AUTO_RATE_MEASURE 5
`define ASIPR_M_RXINV 4
`define ASIPR_M_FAST 3
`define ASIPR_M_PD_HI 2
`define ASIPR_M_PD_LO 1
`define ASIPR_M_STOP2 0
`define ASIPR_MODE_WMASK 16'hBBFF
`define ASIPR_MODE_RST 16'h0000
// ====================================================
// status register fields
`define ASIPR_S_TXIS1 15
`define ASIPR_S_TXINV 14
`define ASIPR_S_TXIS0 13
`define ASIPR_S_RXEN 12
`define ASIPR_S_BRK 11
`define ASIPR_S_TXEN 10
`define ASIPR_S_TXBF 9
`define ASIPR_S_TX_ALL_EMPTY 8
`define ASIPR_S_RXIS1 7
`define ASIPR_S_RXIS0 6
`define ASIPR_S_ADDRESS_DETECT_ON 5
`define ASIPR_S_RECEIVER_IDLE_FLAG 4
`define ASIPR_S_PARITY_ERROR_FLAG 3
`define ASIPR_S_FRAMING_ERROR_FLAG 2
`define ASIPR_S_OVERRUN_ERROR_FLAG 1
`define ASIPR_S_RXDA 0
`define ASIPR_DIV_RST 16'h0000
// ====================================================
// codes and timing counts
`define ASIPR_PIN_TXRX 2'h0
`define ASIPR_PIN_RTS 2'h1
`define ASIPR_PIN_FLOW 2'h2
`define ASIPR_PIN_BCLK 2'h3
`define ASIPR_PD_8N 2'h0
`define ASIPR_PD_8E 2'h1
`define ASIPR_PD_8O 2'h2
`define ASIPR_PD_9N 2'h3
`define ASIPR_SUB_STD 4'hF
`define ASIPR_SUB_FAST 4'h3
`define ASIPR_IR_PULSE 4'h3
`define ASIPR_IR_HOLD 5'h10
`define ASIPR_BRK_FRAME 14'h2000
`define ASIPR_BRK_BITS 4'hE
`endif

// *** verilog/asipr_fifo.v ***
`timescale 1ns/1ps
`default_nettype none
module asipr_fifo #(
   parameter WIDTH = 9,
   parameter DEPTH = 4,
   parameter AW = 2
) (
   // clock and reset
   input wire clk,
   input wire rst,
   input wire flush,
   // fill side
   input wire in_valid,
   output wire in_ready,
   input wire [WIDTH-1:0] in_data,
   // drain side
   output wire out_valid,
   input wire out_ready,
   output wire [WIDTH-1:0] out_data,
   output reg [AW:0] count
);
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW-1:0] wr_ptr;
   reg [AW-1:0] rd_ptr;
   wire push;
   wire pop;
   assign in_ready = (count != DEPTH[AW:0]);
   assign out_valid = (count != {(AW+1){1'b0}});
   assign out_data = mem[rd_ptr];
   assign push = in_valid & in_ready;
   assign pop = out_valid & out_ready;
   always @(posedge clk) begin
      if (push)
         mem[wr_ptr] <= in_data;
   end
   always @(posedge clk) begin
      if (rst | flush) begin
         wr_ptr <= {AW{1'b0}};
         rd_ptr <= {AW{1'b0}};
         count <= {(AW+1){1'b0}};
      end else begin
         if (push)
            wr_ptr <= (wr_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr + 1'b1;
         if (pop)
            rd_ptr <= (rd_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr + 1'b1;
         if (push & ~pop)
            count <= count + 1'b1;
         else if (pop & ~push)
            count <= count - 1'b1;
      end
   end
endmodule
`default_nettype wire

// *** verilog/asipr_uart.v ***
// The register addresses and the Avalon-MM slave port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "asipr_defines.vh"
module asipr_uart (
   // clock and reset
   input wire clk,
   input wire rst,
   // avalon-mm slave
   input wire [4:0] avs_address,
   input wire avs_read,
   input wire avs_write,
   input wire [31:0] avs_writedata,
   input wire [3:0] avs_byteenable,
   output reg [31:0] avs_readdata,
   output reg avs_waitrequest,
   // serial pins
   input wire serial_in_pin,
   output reg serial_out_pin,
   output reg serial_out_oe,
   input wire clear_to_send_pin_n,
   output reg request_to_send_pin_n,
   output reg request_to_send_oe,
   // chip power state
   input wire chip_idle,
   input wire chip_sleep,
   // interrupt pulses
   output reg tx_irq,
   output reg rx_irq,
   output reg wake_irq
);
   localparam RX_IDLE = 4'b0001;
   localparam RX_START = 4'b0010;
   localparam RX_DATA = 4'b0100;
   localparam RX_STOP = 4'b1000;

   // ====================================================
   // registers
   reg [15:0] mode;
   reg [15:0] divisor;
   reg [1:0] tx_isel;
   reg tx_inv;
   reg rx_on;
   reg brk;
   reg tx_on;
   reg [1:0] rx_isel;
   reg addr_det;
   reg overrun_error_flag;
   reg [15:0] next_mode;
   reg [15:0] next_stat;
   wire [15:0] wmask;
   wire req;
   wire acc;
   wire [2:0] sel;
   assign req = avs_read | avs_write;
   assign acc = req & ~avs_waitrequest;
   assign sel = avs_address[4:2];
   assign wmask = {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

   wire on = mode[`ASIPR_M_ON];
   wire [1:0] pins = mode[`ASIPR_M_PIN_HI:`ASIPR_M_PIN_LO];
   wire [1:0] pd = mode[`ASIPR_M_PD_HI:`ASIPR_M_PD_LO];
   wire fast = mode[`ASIPR_M_FAST];
   wire auto_rate_measure = mode[`ASIPR_M_AUTO_RATE_MEASURE];
   wire run = on & ~(mode[`ASIPR_M_HALT] & chip_idle);
   wire ir_on = mode[`ASIPR_M_INFRARED_CODEC_ON] & ~fast;
   wire [3:0] sub_last = fast ? `ASIPR_SUB_FAST : `ASIPR_SUB_STD;
   wire wr_mode = acc & avs_write & (sel == `ASIPR_OFS_MODE);
   wire wr_stat = acc & avs_write & (sel == `ASIPR_OFS_STAT);
   wire wr_div = acc & avs_write & (sel == `ASIPR_OFS_DIV) & (|avs_byteenable[1:0]);
   wire wr_txd = acc & avs_write & (sel == `ASIPR_OFS_TXD) & avs_byteenable[0];
   wire rd_rxd = acc & avs_read & (sel == `ASIPR_OFS_RXD);
   wire overrun_error_flag_clr = wr_stat & avs_byteenable[0] & overrun_error_flag & ~avs_writedata[`ASIPR_S_OVERRUN_ERROR_FLAG];

   // ====================================================
   // pin synchronisers
   reg rx_s1;
   reg rx_s2;
   reg rx_s3;
   reg cts_s1;
   reg cts_s2;
   always @(posedge clk) begin
      rx_s1 <= serial_in_pin;
      rx_s2 <= rx_s1;
      rx_s3 <= rx_s2;
      cts_s1 <= clear_to_send_pin_n;
      cts_s2 <= cts_s1;
   end

   // ====================================================
   // rate generator
   reg [15:0] brg_cnt;
   reg tick;
   always @(posedge clk) begin
      if (rst | wr_div | ~run) begin
         brg_cnt <= 16'h0000;
         tick <= 1'b0;
      end else if (brg_cnt == divisor) begin
         brg_cnt <= 16'h0000;
         tick <= 1'b1;
      end else begin
         brg_cnt <= brg_cnt + 16'h0001;
         tick <= 1'b0;
      end
   end

   // ====================================================
   // transmit path
   wire tx_flush = rst | ~tx_on | ~on;
   wire tx_ready;
   wire tx_avail;
   wire [8:0] tx_head;
   wire [2:0] tx_count;
   reg tx_busy;
   reg tx_brk_frame;
   reg [13:0] tx_sh;
   reg [3:0] tx_left;
   reg [3:0] tx_sub;
   wire cts_ok = (pins != `ASIPR_PIN_FLOW) | ~cts_s2;
   wire tx_pop = run & tx_avail & ~tx_busy & cts_ok;
   wire tx_done = tick & tx_busy & (tx_sub == sub_last) & (tx_left == 4'h1);
   wire tx_ninth = (pd == `ASIPR_PD_9N) ? tx_head[8] :
                   (pd == `ASIPR_PD_8E) ? ^tx_head[7:0] :
                   (pd == `ASIPR_PD_8O) ? ~^tx_head[7:0] : 1'b1;
   wire [3:0] tx_nbits = 4'hA + {3'b000, pd != `ASIPR_PD_8N}
                         + {3'b000, mode[`ASIPR_M_STOP2]};

   asipr_fifo #(.WIDTH(9), .DEPTH(4), .AW(2)) u_tx_fifo (
      .clk(clk),
      .rst(rst),
      .flush(tx_flush),
      .in_valid(wr_txd),
      .in_ready(tx_ready),
      .in_data(avs_writedata[8:0]),
      .out_valid(tx_avail),
      .out_ready(tx_pop),
      .out_data(tx_head),
      .count(tx_count)
   );

   always @(posedge clk) begin
      if (tx_flush) begin
         tx_busy <= 1'b0;
         tx_brk_frame <= 1'b0;
         tx_sh <= 14'h3FFF;
         tx_left <= 4'h0;
         tx_sub <= 4'h0;
      end else if (tx_pop) begin
         tx_busy <= 1'b1;
         tx_sub <= 4'h0;
         tx_brk_frame <= brk;
         if (brk) begin
            // the queued character is consumed as the break trigger
            tx_sh <= `ASIPR_BRK_FRAME;
            tx_left <= `ASIPR_BRK_BITS;
         end else begin
            tx_sh <= {4'hF, tx_ninth, tx_head[7:0], 1'b0};
            tx_left <= tx_nbits;
         end
      end else if (tick & tx_busy) begin
         if (tx_sub == sub_last) begin
            tx_sub <= 4'h0;
            tx_sh <= {1'b1, tx_sh[13:1]};
            tx_left <= tx_left - 4'h1;
            if (tx_left == 4'h1)
               tx_busy <= 1'b0;
         end else begin
            tx_sub <= tx_sub + 4'h1;
         end
      end
   end

   wire tx_bit = tx_busy ? tx_sh[0] : 1'b1;
   // short pulse in the first sixteenths of each zero bit
   wire ir_pulse = tx_busy & ~tx_sh[0] & (tx_sub < `ASIPR_IR_PULSE);
   wire tx_level = (ir_on ? ir_pulse : tx_bit) ^ tx_inv;

   reg tx_evt;
   always @(*) begin
      tx_evt = 1'b0;
      case (tx_isel)
         2'b00: tx_evt = tx_pop;
         2'b01: tx_evt = tx_done & ~tx_avail;
         2'b10: tx_evt = tx_pop & (tx_count == 3'h1);
         default: tx_evt = 1'b0;
      endcase
   end

   // ====================================================
   // receive path
   reg [3:0] rx_state;
   reg [3:0] rx_sub;
   reg [3:0] rx_n;
   reg [8:0] rx_sh;
   reg [4:0] ir_hold;
   reg rx_prev;
   wire rx_run = run & rx_on;
   wire rx_raw = mode[`ASIPR_M_LOOP] ? serial_out_pin : rx_s2;
   wire rx_pol = rx_raw ^ mode[`ASIPR_M_RXINV];
   wire rx_bit = ir_on ? (ir_hold == 5'h00) : rx_pol;
   wire [3:0] rx_nd = (pd == `ASIPR_PD_8N) ? 4'h8 : 4'h9;
   wire [8:0] rx_data = (pd == `ASIPR_PD_8N) ? {1'b0, rx_sh[8:1]} :
                        (pd == `ASIPR_PD_9N) ? rx_sh : {1'b0, rx_sh[7:0]};
   wire rx_parity_error_flag = (pd == `ASIPR_PD_8E) ? ^rx_sh :
                  (pd == `ASIPR_PD_8O) ? ~^rx_sh : 1'b0;
   wire rx_fin = tick & (rx_state == RX_STOP) & (rx_sub == sub_last);
   // nine-bit data characters are dropped while address detect is on
   wire rx_keep = ~(addr_det & (pd == `ASIPR_PD_9N) & ~rx_sh[8]);
   wire rx_ready;
   wire rx_avail;
   wire [10:0] rx_head;
   wire [2:0] rx_count;
   wire rx_push = rx_fin & rx_keep & rx_ready;
   wire rx_ovf = rx_fin & rx_keep & ~rx_ready;
   wire rx_flush = rst | overrun_error_flag_clr;

   asipr_fifo #(.WIDTH(11), .DEPTH(4), .AW(2)) u_rx_fifo (
      .clk(clk),
      .rst(rst),
      .flush(rx_flush),
      .in_valid(rx_push),
      .in_ready(rx_ready),
      .in_data({rx_parity_error_flag, ~rx_bit, rx_data}),
      .out_valid(rx_avail),
      .out_ready(rd_rxd),
      .out_data(rx_head),
      .count(rx_count)
   );

   always @(posedge clk) begin
      if (rst | ~ir_on)
         ir_hold <= 5'h00;
      else if (~rx_pol)
         ir_hold <= `ASIPR_IR_HOLD;
      else if (tick & (ir_hold != 5'h00))
         ir_hold <= ir_hold - 5'h01;
   end

   always @(posedge clk) begin
      if (rx_flush | ~rx_run) begin
         rx_state <= RX_IDLE;
         rx_sub <= 4'h0;
         rx_n <= 4'h0;
         rx_sh <= 9'h000;
      end else begin
         case (rx_state)
            RX_IDLE: begin
               rx_sub <= 4'h0;
               if (~auto_rate_measure & rx_prev & ~rx_bit) // a fall only: a held-low line must not restart
                  rx_state <= RX_START;
            end
            RX_START: begin
               if (tick) begin
                  if (rx_sub == {1'b0, sub_last[3:1]}) begin
                     rx_sub <= 4'h0;
                     rx_n <= 4'h0;
                     rx_state <= rx_bit ? RX_IDLE : RX_DATA;
                  end else begin
                     rx_sub <= rx_sub + 4'h1;
                  end
               end
            end
            RX_DATA: begin
               if (tick) begin
                  if (rx_sub == sub_last) begin
                     rx_sub <= 4'h0;
                     rx_sh <= {rx_bit, rx_sh[8:1]};
                     rx_n <= rx_n + 4'h1;
                     if (rx_n == rx_nd - 4'h1)
                        rx_state <= RX_STOP;
                  end else begin
                     rx_sub <= rx_sub + 4'h1;
                  end
               end
            end
            RX_STOP: begin
               if (tick) begin
                  if (rx_sub == sub_last)
                     rx_state <= RX_IDLE;
                  else
                     rx_sub <= rx_sub + 4'h1;
               end
            end
            default: rx_state <= RX_IDLE;
         endcase
      end
   end

   reg rx_evt;
   always @(*) begin
      case (rx_isel)
         2'b11: rx_evt = rx_push & (rx_count == 3'h3);
         2'b10: rx_evt = rx_push & (rx_count == 3'h2);
         default: rx_evt = rx_push;
      endcase
   end

   // ====================================================
   // auto-baud: 55h gives five falling edges spanning eight bits
   reg [22:0] ab_cnt;
   reg [2:0] ab_edges;
   wire ab_fall = rx_prev & ~rx_bit;
   wire ab_done = auto_rate_measure & rx_run & ab_fall & (ab_edges == 3'h4);
   wire [22:0] ab_div = fast ? (ab_cnt >> 5) : (ab_cnt >> 7);
   always @(posedge clk) begin
      rx_prev <= rx_bit;
      if (rst | ~auto_rate_measure | ~rx_run) begin
         ab_cnt <= 23'h000000;
         ab_edges <= 3'h0;
      end else begin
         ab_cnt <= ab_cnt + 23'h000001;
         if (ab_fall) begin
            if (ab_edges == 3'h0)
               ab_cnt <= 23'h000000;
            ab_edges <= (ab_edges == 3'h4) ? 3'h0 : ab_edges + 3'h1;
         end
      end
   end

   // ====================================================
   // wake from sleep on start edge
   wire wake_on = mode[`ASIPR_M_WAKE] & chip_sleep;
   wire wake_fall = wake_on & rx_s3 & ~rx_s2;
   wire wake_rise = wake_on & ~rx_s3 & rx_s2;

   // ====================================================
   // register writes and hardware clears
   always @(*) begin
      next_mode = (mode & ~(wmask & `ASIPR_MODE_WMASK))
                  | (avs_writedata[15:0] & wmask & `ASIPR_MODE_WMASK);
      next_stat = avs_writedata[15:0];
   end

   always @(posedge clk) begin
      if (rst) begin
         mode <= `ASIPR_MODE_RST;
         divisor <= `ASIPR_DIV_RST;
         tx_isel <= 2'b00;
         tx_inv <= 1'b0;
         rx_on <= 1'b0;
         brk <= 1'b0;
         tx_on <= 1'b0;
         rx_isel <= 2'b00;
         addr_det <= 1'b0;
         overrun_error_flag <= 1'b0;
      end else begin
         if (wr_mode)
            mode <= next_mode;
         if (ab_done)
            mode[`ASIPR_M_AUTO_RATE_MEASURE] <= 1'b0;
         if (wake_rise)
            mode[`ASIPR_M_WAKE] <= 1'b0;
         if (wr_div)
            divisor <= (divisor & ~wmask) | (avs_writedata[15:0] & wmask);
         else if (ab_done)
            divisor <= ab_div[15:0] - 16'h0001;
         if (wr_stat & avs_byteenable[1]) begin
            tx_isel <= {next_stat[`ASIPR_S_TXIS1], next_stat[`ASIPR_S_TXIS0]};
            tx_inv <= next_stat[`ASIPR_S_TXINV];
            rx_on <= next_stat[`ASIPR_S_RXEN];
            tx_on <= next_stat[`ASIPR_S_TXEN];
         end
         // hardware completion clear wins over a same-cycle write
         if (tx_done & tx_brk_frame)
            brk <= 1'b0;
         else if (wr_stat & avs_byteenable[1])
            brk <= next_stat[`ASIPR_S_BRK];
         if (wr_stat & avs_byteenable[0]) begin
            rx_isel <= {next_stat[`ASIPR_S_RXIS1], next_stat[`ASIPR_S_RXIS0]};
            addr_det <= next_stat[`ASIPR_S_ADDRESS_DETECT_ON];
         end
         overrun_error_flag <= rx_ovf | (overrun_error_flag & ~overrun_error_flag_clr);
      end
   end

   // ====================================================
   // pin drivers and interrupt pulses
   always @(posedge clk) begin
      if (rst) begin
         serial_out_pin <= 1'b1;
         serial_out_oe <= 1'b0;
         request_to_send_pin_n <= 1'b1;
         request_to_send_oe <= 1'b0;
         tx_irq <= 1'b0;
         rx_irq <= 1'b0;
         wake_irq <= 1'b0;
      end else begin
         serial_out_pin <= tx_level;
         serial_out_oe <= on & tx_on;
         request_to_send_oe <= on & (pins != `ASIPR_PIN_TXRX);
         if (pins == `ASIPR_PIN_BCLK)
            request_to_send_pin_n <= tick;
         else if (mode[`ASIPR_M_RTS_PIN_MODE])
            request_to_send_pin_n <= ~tx_busy;
         else
            request_to_send_pin_n <= ~rx_ready;
         tx_irq <= tx_evt;
         rx_irq <= rx_evt;
         wake_irq <= wake_fall;
      end
   end

   // ====================================================
   // bus slave: one wait cycle, then the answer
   always @(posedge clk) begin
      if (rst) begin
         avs_waitrequest <= 1'b1;
         avs_readdata <= 32'h00000000;
      end else if (avs_waitrequest & req) begin
         avs_waitrequest <= 1'b0;
         case (sel)
            `ASIPR_OFS_MODE: avs_readdata <= {16'h0000, mode};
            `ASIPR_OFS_STAT: avs_readdata <= {16'h0000, tx_isel[1], tx_inv, tx_isel[0],
               rx_on, brk, tx_on, ~tx_ready, ~tx_busy & ~tx_avail,
               rx_isel, addr_det, rx_state == RX_IDLE,
               rx_avail & rx_head[10], rx_avail & rx_head[9], overrun_error_flag, rx_avail};
            `ASIPR_OFS_DIV: avs_readdata <= {16'h0000, divisor};
            `ASIPR_OFS_RXD: avs_readdata <= {23'h000000, rx_avail ? rx_head[8:0] : 9'h000};
            default: avs_readdata <= 32'h00000000;
         endcase
      end else begin
         avs_waitrequest <= 1'b1;
      end
   end
endmodule
`default_nettype wire
